// ==== verilog/isp_cfg.svh ====
// Constants of the test-port and flash programming block.
// Assumes inclusion by bare name; holds definitions only.
`ifndef ISP_CFG_SVH
`define ISP_CFG_SVH
`define IR_LEN 10
`define IR_CAPTURE 10'h001
`define IR_IDCODE 10'h006
`define IR_BYPASS 10'h3ff
`define IR_USER_A 10'h00c
`define IR_USER_B 10'h00e
`define IR_ISP_ENTER 10'h2cc
`define IR_ISP_EXIT 10'h201
`define IR_ADDR 10'h203
`define IR_DATA 10'h2e5
`define IR_ERASE_CFG 10'h2f2
`define IR_ERASE_UFM 10'h2f3
`define IR_ERASE_ALL 10'h2f4
`define IR_PROGRAM 10'h2f7
`define IR_VERIFY 10'h205
`define IR_CLAMP 10'h233
`define ID_LSB 1'h1
`define ERASE_MS 500
`define PROG_US 75
`define CLK_MHZ 125
`define CLAMP_HOLD 2'h0
`define CLAMP_HIGH 2'h1
`define CLAMP_LOW 2'h2
`define CLAMP_FLOAT 2'h3
`endif

// ==== verilog/isp_pkg.sv ====
// Types of the test-port and flash programming block.
// Assumes nothing of its surroundings.
package isp_pkg;
    // One-hot states of the test access port controller.
    typedef enum logic [15:0] {
        TLR = 16'h0001, RTI = 16'h0002, SEL_DR = 16'h0004, CAP_DR = 16'h0008,
        SH_DR = 16'h0010, EX1_DR = 16'h0020, PA_DR = 16'h0040, EX2_DR = 16'h0080,
        UPD_DR = 16'h0100, SEL_IR = 16'h0200, CAP_IR = 16'h0400, SH_IR = 16'h0800,
        EX1_IR = 16'h1000, PA_IR = 16'h2000, EX2_IR = 16'h4000, UPD_IR = 16'h8000
    } tap_state_e;
endpackage

// ==== verilog/jtag_isp_flash_programmer.sv ====
// Test access port, user chains and flash programming controller.
// Assumes test-port pins arrive asynchronously and are sampled by CLK_I.
`timescale 1ns/1ps
`default_nettype none
`include "isp_cfg.svh"
module jtag_isp_flash_programmer #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 6,
    parameter int UFM_SECT = 2,
    parameter int NPINS = 8,
    parameter logic [3:0] ID_VER = 4'h1, // Arbitrary value.
    parameter logic [15:0] ID_PART = 16'h1234, // Arbitrary value.
    parameter logic [10:0] ID_MFR = 11'h2a5, // Arbitrary value.
    parameter logic DONE_INIT = 1'h1,
    parameter int ERASE_CYC = `ERASE_MS * `CLK_MHZ * 1000,
    parameter int PROG_CYC = `PROG_US * `CLK_MHZ
) (
    input wire logic CLK_I, // System clock.
    input wire logic RST_I, // Synchronous reset.
    input wire logic TCK_I, // Test clock pin.
    input wire logic TMS_I, // Test mode select pin.
    input wire logic TDI_I, // Test data in pin.
    output logic TDO_O, // Test data out.
    output logic TDO_OE_O, // Test data out enable.
    output logic [15:0] USER_TAP_STATE_O, // Port state to logic.
    output logic USER_TCK_O, // Synchronised test clock.
    output logic USER_TMS_O, // Synchronised mode select.
    output logic USER_TDI_O, // Synchronised data in.
    output logic USER_SEL_A_O, // User chain a selected.
    output logic USER_SEL_B_O, // User chain b selected.
    input wire logic USER_TDO_A_I, // Chain a serial out.
    input wire logic USER_TDO_B_I, // Chain b serial out.
    input wire logic [NPINS-1:0] USER_PIN_OUT_I, // Core pin values.
    input wire logic [NPINS-1:0] USER_PIN_OE_I, // Core pin enables.
    output logic [NPINS-1:0] PIN_OUT_O, // Pin values.
    output logic [NPINS-1:0] PIN_OE_O, // Pin enables.
    output logic [NPINS-1:0] PIN_PULLUP_O, // Weak pull-ups.
    output logic ISP_MODE_O, // Programming mode active.
    output logic PULSE_BUSY_O // Flash pulse running.
);
    localparam int SW = (UFM_SECT > 1) ? $clog2(UFM_SECT) : 1;
    localparam logic [31:0] IDWORD = {ID_VER, ID_PART, ID_MFR, `ID_LSB};

    // ****************************************
    // Helpers
    // ****************************************
    // Next port state; used for every clock rise.
    function automatic isp_pkg::tap_state_e tap_next(input isp_pkg::tap_state_e s, input logic m);
        case (s)
            isp_pkg::TLR: tap_next = m ? isp_pkg::TLR : isp_pkg::RTI;
            isp_pkg::RTI: tap_next = m ? isp_pkg::SEL_DR : isp_pkg::RTI;
            isp_pkg::SEL_DR: tap_next = m ? isp_pkg::SEL_IR : isp_pkg::CAP_DR;
            isp_pkg::CAP_DR: tap_next = m ? isp_pkg::EX1_DR : isp_pkg::SH_DR;
            isp_pkg::SH_DR: tap_next = m ? isp_pkg::EX1_DR : isp_pkg::SH_DR;
            isp_pkg::EX1_DR: tap_next = m ? isp_pkg::UPD_DR : isp_pkg::PA_DR;
            isp_pkg::PA_DR: tap_next = m ? isp_pkg::EX2_DR : isp_pkg::PA_DR;
            isp_pkg::EX2_DR: tap_next = m ? isp_pkg::UPD_DR : isp_pkg::SH_DR;
            isp_pkg::SEL_IR: tap_next = m ? isp_pkg::TLR : isp_pkg::CAP_IR;
            isp_pkg::CAP_IR: tap_next = m ? isp_pkg::EX1_IR : isp_pkg::SH_IR;
            isp_pkg::SH_IR: tap_next = m ? isp_pkg::EX1_IR : isp_pkg::SH_IR;
            isp_pkg::EX1_IR: tap_next = m ? isp_pkg::UPD_IR : isp_pkg::PA_IR;
            isp_pkg::PA_IR: tap_next = m ? isp_pkg::EX2_IR : isp_pkg::PA_IR;
            isp_pkg::EX2_IR: tap_next = m ? isp_pkg::UPD_IR : isp_pkg::SH_IR;
            isp_pkg::UPD_DR, isp_pkg::UPD_IR: tap_next = m ? isp_pkg::SEL_DR : isp_pkg::RTI;
            default: tap_next = isp_pkg::TLR;
        endcase
    endfunction

    // Length of the data chain that an instruction selects.
    function automatic int dr_len(input logic [`IR_LEN-1:0] ir);
        case (ir)
            `IR_IDCODE: dr_len = 32;
            `IR_ADDR: dr_len = ADDR_W + 1;
            `IR_DATA, `IR_PROGRAM, `IR_VERIFY: dr_len = DATA_W;
            `IR_CLAMP: dr_len = 2 * NPINS;
            default: dr_len = 1;
        endcase
    endfunction

    // ****************************************
    // Pin sampling
    // ****************************************
    logic [2:0] meta_reg, sync_reg;
    logic tck_d_reg;
    // Two stages per pin, plus a third on the test clock for edge detection; the first stage never feeds the logic.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            meta_reg <= 3'h0;
            sync_reg <= 3'h0;
            tck_d_reg <= 1'h0;
        end else begin
            meta_reg <= {TCK_I, TMS_I, TDI_I};
            sync_reg <= meta_reg;
            tck_d_reg <= sync_reg[2];
        end
    end
    wire tck_rise = sync_reg[2] & ~tck_d_reg;
    wire tck_fall = ~sync_reg[2] & tck_d_reg;
    wire tms_s = sync_reg[1];
    wire tdi_s = sync_reg[0];

    // ****************************************
    // Port controller and chains
    // ****************************************
    isp_pkg::tap_state_e st_reg;
    logic [`IR_LEN-1:0] ir_reg, irs_reg;
    logic [31:0] dr_reg;
    logic [ADDR_W:0] addr_reg;
    logic [DATA_W-1:0] data_reg;
    logic [2*NPINS-1:0] clamp_reg;
    logic clamp_en_reg, isp_reg, done_reg;
    logic [DATA_W-1:0] cfm_mem [2**ADDR_W];
    logic [DATA_W-1:0] ufm_mem [2**ADDR_W];
    wire [DATA_W-1:0] rd_word = addr_reg[ADDR_W] ? ufm_mem[addr_reg[ADDR_W-1:0]] : cfm_mem[addr_reg[ADDR_W-1:0]];
    wire user_ir = (ir_reg == `IR_USER_A) || (ir_reg == `IR_USER_B);

    // State, instruction and data chains all move on a test clock rise.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            st_reg <= isp_pkg::TLR;
            ir_reg <= `IR_IDCODE;
            irs_reg <= `IR_CAPTURE;
            dr_reg <= 32'h0;
        end else if (tck_rise) begin
            st_reg <= tap_next(st_reg, tms_s);
            case (st_reg)
                isp_pkg::TLR: ir_reg <= `IR_IDCODE;
                isp_pkg::CAP_IR: irs_reg <= `IR_CAPTURE;
                isp_pkg::SH_IR: irs_reg <= {tdi_s, irs_reg[`IR_LEN-1:1]};
                isp_pkg::UPD_IR: ir_reg <= irs_reg;
                isp_pkg::CAP_DR: begin
                    case (ir_reg)
                        `IR_IDCODE: dr_reg <= IDWORD;
                        `IR_ADDR: dr_reg <= 32'(addr_reg);
                        `IR_VERIFY: dr_reg <= 32'(rd_word);
                        `IR_DATA, `IR_PROGRAM: dr_reg <= 32'(data_reg);
                        `IR_CLAMP: dr_reg <= 32'(clamp_reg);
                        default: dr_reg <= 32'h0;
                    endcase
                end
                isp_pkg::SH_DR: begin
                    dr_reg <= dr_reg >> 1;
                    dr_reg[dr_len(ir_reg)-1] <= tdi_s;
                end
                default: begin
                end
            endcase
        end
    end

    // Data out changes on the falling test clock; user chains bypass the scan cells.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            TDO_O <= 1'h0;
            TDO_OE_O <= 1'h0;
        end else if (tck_fall) begin
            TDO_OE_O <= (st_reg == isp_pkg::SH_IR) || (st_reg == isp_pkg::SH_DR);
            if (st_reg == isp_pkg::SH_IR) begin
                TDO_O <= irs_reg[0];
            end else if (ir_reg == `IR_USER_A) begin
                TDO_O <= USER_TDO_A_I;
            end else if (ir_reg == `IR_USER_B) begin
                TDO_O <= USER_TDO_B_I;
            end else begin
                TDO_O <= dr_reg[0];
            end
        end
    end

    // Port state and pins go to the logic array only under a user instruction.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            USER_TAP_STATE_O <= 16'h0;
            {USER_TCK_O, USER_TMS_O, USER_TDI_O} <= 3'h0;
            {USER_SEL_A_O, USER_SEL_B_O} <= 2'h0;
        end else begin
            USER_TAP_STATE_O <= user_ir ? st_reg : 16'h0;
            {USER_TCK_O, USER_TMS_O, USER_TDI_O} <= user_ir ? sync_reg : 3'h0;
            USER_SEL_A_O <= (ir_reg == `IR_USER_A);
            USER_SEL_B_O <= (ir_reg == `IR_USER_B);
        end
    end

    // ****************************************
    // Programming controller
    // ****************************************
    logic [`IR_LEN-1:0] op_reg;
    logic [31:0] cnt_reg;
    wire upd_ir = tck_rise && (st_reg == isp_pkg::UPD_IR);
    wire upd_dr = tck_rise && (st_reg == isp_pkg::UPD_DR);
    wire is_pulse_op = (irs_reg == `IR_ERASE_CFG) || (irs_reg == `IR_ERASE_UFM) ||
        (irs_reg == `IR_ERASE_ALL) || (irs_reg == `IR_PROGRAM);
    wire [31:0] pulse_cyc = (op_reg == `IR_PROGRAM) ? PROG_CYC : ERASE_CYC;
    wire pulse_fire = PULSE_BUSY_O && (st_reg == isp_pkg::RTI) && (cnt_reg == pulse_cyc - 32'h1);

    // Pulse arms on the instruction and counts only while idle; leaving idle after the count has started cancels it.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            PULSE_BUSY_O <= 1'h0;
            op_reg <= `IR_BYPASS;
            cnt_reg <= 32'h0;
        end else if (upd_ir) begin
            PULSE_BUSY_O <= isp_reg && is_pulse_op;
            op_reg <= irs_reg;
            cnt_reg <= 32'h0;
        end else if (PULSE_BUSY_O) begin
            if (st_reg == isp_pkg::RTI) begin
                cnt_reg <= cnt_reg + 32'h1;
                PULSE_BUSY_O <= !pulse_fire;
            end else if (cnt_reg != 32'h0) begin
                PULSE_BUSY_O <= 1'h0;
            end
        end
    end

    // Flash cells: erase sets ones, programming can only clear bits.
    always_ff @(posedge CLK_I) begin
        if (pulse_fire) begin
            for (int i = 0; i < 2**ADDR_W; i++) begin
                if (op_reg == `IR_ERASE_CFG || op_reg == `IR_ERASE_ALL) begin
                    cfm_mem[i] <= '1;
                end
                if (op_reg == `IR_ERASE_ALL || (op_reg == `IR_ERASE_UFM &&
                    SW'(i >> (ADDR_W - SW)) == addr_reg[ADDR_W-1 -: SW])) begin
                    ufm_mem[i] <= '1;
                end
            end
            if (op_reg == `IR_PROGRAM && addr_reg[ADDR_W]) begin
                ufm_mem[addr_reg[ADDR_W-1:0]] <= ufm_mem[addr_reg[ADDR_W-1:0]] & data_reg;
            end else if (op_reg == `IR_PROGRAM) begin
                cfm_mem[addr_reg[ADDR_W-1:0]] <= cfm_mem[addr_reg[ADDR_W-1:0]] & data_reg;
            end
        end
    end

    // Mode, address, data, clamp and the completion bit.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            isp_reg <= 1'h0;
            clamp_en_reg <= 1'h0;
            done_reg <= DONE_INIT;
            addr_reg <= '0;
            data_reg <= '0;
            clamp_reg <= '0;
        end else begin
            if (upd_ir && irs_reg == `IR_ISP_ENTER) begin
                isp_reg <= 1'h1;
            end else if (upd_ir && irs_reg == `IR_ISP_EXIT) begin
                isp_reg <= 1'h0;
                clamp_en_reg <= 1'h0;
            end
            if (upd_dr && ir_reg == `IR_ADDR) begin
                addr_reg <= dr_reg[ADDR_W:0];
            end
            if (upd_dr && (ir_reg == `IR_DATA || ir_reg == `IR_PROGRAM)) begin
                data_reg <= dr_reg[DATA_W-1:0];
            end
            if (upd_dr && ir_reg == `IR_CLAMP) begin
                clamp_reg <= dr_reg[2*NPINS-1:0];
                clamp_en_reg <= 1'h1;
            end
            // The top configuration word is written last, so it carries the completion bit.
            if (pulse_fire && op_reg != `IR_PROGRAM && op_reg != `IR_ERASE_UFM) begin
                done_reg <= 1'h0;
            end else if (pulse_fire && addr_reg == {1'h0, {ADDR_W{1'h1}}}) begin
                done_reg <= 1'h1;
            end
        end
    end

    // ****************************************
    // Pin control
    // ****************************************
    logic [NPINS-1:0] hold_out_reg, hold_oe_reg;
    // Values caught at entry let a clamped output keep its level; inputs stay floating.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            hold_out_reg <= '0;
            hold_oe_reg <= '0;
        end else if (!isp_reg) begin
            hold_out_reg <= USER_PIN_OUT_I;
            hold_oe_reg <= USER_PIN_OE_I & {NPINS{done_reg}};
        end
    end

    // All pin outputs change on one edge together, so entry and exit cannot glitch.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            PIN_OUT_O <= '0;
            PIN_OE_O <= '0;
            PIN_PULLUP_O <= '1;
            ISP_MODE_O <= 1'h0;
        end else begin
            ISP_MODE_O <= isp_reg;
            for (int p = 0; p < NPINS; p++) begin
                if (!isp_reg && done_reg) begin
                    PIN_OUT_O[p] <= USER_PIN_OUT_I[p];
                    PIN_OE_O[p] <= USER_PIN_OE_I[p];
                    PIN_PULLUP_O[p] <= 1'h0;
                end else if (isp_reg && clamp_en_reg && clamp_reg[2*p +: 2] != `CLAMP_FLOAT) begin
                    PIN_OUT_O[p] <= (clamp_reg[2*p +: 2] == `CLAMP_HOLD) ? hold_out_reg[p] :
                        (clamp_reg[2*p +: 2] == `CLAMP_HIGH);
                    PIN_OE_O[p] <= (clamp_reg[2*p +: 2] != `CLAMP_HOLD) || hold_oe_reg[p];
                    PIN_PULLUP_O[p] <= 1'h0;
                end else begin
                    PIN_OUT_O[p] <= 1'h0;
                    PIN_OE_O[p] <= 1'h0;
                    PIN_PULLUP_O[p] <= 1'h1;
                end
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_idcode_capture: assert property (@(posedge CLK_I) disable iff (RST_I)
        (tck_rise && st_reg == isp_pkg::CAP_DR && ir_reg == `IR_IDCODE) |=> dr_reg[0] && dr_reg[31:28] == ID_VER)
        else $error("identification capture wrong");
    a_user_expose: assert property (@(posedge CLK_I) disable iff (RST_I)
        (ir_reg == `IR_USER_A) |=> USER_SEL_A_O && USER_TAP_STATE_O == $past(st_reg))
        else $error("user chain a not exposed");
    a_user_tdo: assert property (@(posedge CLK_I) disable iff (RST_I)
        (tck_fall && st_reg == isp_pkg::SH_DR && ir_reg == `IR_USER_B) |=> TDO_O == $past(USER_TDO_B_I))
        else $error("user chain b data out wrong");
    a_chain_apart: assert property (@(posedge CLK_I) disable iff (RST_I)
        !(USER_SEL_A_O && USER_SEL_B_O))
        else $error("both user chains selected");
    a_isp_float: assert property (@(posedge CLK_I) disable iff (RST_I)
        (isp_reg && !clamp_en_reg) |=> PIN_OE_O == '0 && PIN_PULLUP_O == '1)
        else $error("pins driven during programming");
    a_done_gate: assert property (@(posedge CLK_I) disable iff (RST_I)
        (!done_reg && !clamp_en_reg) |=> PIN_OE_O == '0)
        else $error("pins driven before completion");
    a_entry_clean: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(isp_reg) |-> !clamp_en_reg ##1 (ISP_MODE_O && PIN_OE_O == '0))
        else $error("entry did not float pins");
    a_exit_clean: assert property (@(posedge CLK_I) disable iff (RST_I)
        ($fell(isp_reg) && done_reg) |=> PIN_OE_O == $past(USER_PIN_OE_I))
        else $error("exit did not restore pins");
    a_pulse_abort: assert property (@(posedge CLK_I) disable iff (RST_I)
        (PULSE_BUSY_O && !upd_ir && st_reg != isp_pkg::RTI && cnt_reg != 32'h0) |=> !PULSE_BUSY_O)
        else $error("pulse ran outside idle");
    a_pulse_length: assert property (@(posedge CLK_I) disable iff (RST_I)
        pulse_fire |-> op_reg != `IR_PROGRAM || cnt_reg == PROG_CYC - 1)
        else $error("program pulse length wrong");
endmodule
`default_nettype wire

// ==== test/jtag_prog_model.sv ====
// Behavioural four-wire test-port programmer for the programming block.
// Assumes the bench supplies its clock and calls the tasks at a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module jtag_prog_model (
    input wire logic clk_i, // Bench clock that paces the port.
    input wire logic tdo_i, // Serial data from the device.
    output logic tck_o, // Test clock, still and low between frames.
    output logic tms_o, // Test mode select.
    output logic tdi_o // Serial data to the device.
);
    // **********************************************************
    // Port driving
    // **********************************************************
    // The port starts still, with mode select high so a reset walk is harmless.
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // One 80 ns test clock period; tdo is the bit presented for this rising edge.
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        repeat (5) @(negedge clk_i);
        tdo = tdo_i;
        tck_o = 1'b1;
        repeat (5) @(negedge clk_i);
        tck_o = 1'b0;
    endtask

    // Five ticks with mode select high reach reset from any state, then park in idle.
    task automatic reset_tap();
        logic b;
        repeat (5) tick(1'b1, 1'b0, b);
        tick(1'b0, 1'b0, b);
    endtask

    // Idle ticks time the erase and program pulses; leaving idle ends them.
    task automatic idle(input int n);
        logic b;
        repeat (n) tick(1'b0, 1'b0, b);
    endtask

    // Full scan from idle back to idle, least significant bit first.
    task automatic scan(input logic ir, input logic [31:0] din, input int len, output logic [31:0] dout);
        logic b;
        dout = '0;
        tick(1'b1, 1'b0, b);
        if (ir) tick(1'b1, 1'b0, b);
        tick(1'b0, 1'b0, b);
        tick(1'b0, 1'b0, b);
        for (int i = 0; i < len; i++) begin
            tick(i == len - 1, din[i], b);
            dout[i] = b;
        end
        tick(1'b1, 1'b0, b);
        tick(1'b0, 1'b0, b);
    endtask
endmodule
`default_nettype wire

// ==== test/jtag_isp_flash_programmer_tb_top.sv ====
// Self-checking bench for the test-port and flash programming block.
// Assumes the programmer model and the design files are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "isp_cfg.svh"
module jtag_isp_flash_programmer_tb_top;
    localparam logic [3:0] ID_V = 4'h3; // Arbitrary value.
    localparam logic [15:0] ID_P = 16'h0abc; // Arbitrary value.
    localparam logic [10:0] ID_M = 11'h155; // Arbitrary value.
    logic clk_i, rst_i, tck, tms, tdi, tdo, tdo_oe, user_tdi, sel_a, sel_b, isp_mode, busy;
    logic user_tck, user_tms, oe_seen, utck_seen;
    logic [15:0] user_state;
    logic [7:0] core_out, core_oe, pin_out, pin_oe, pin_pu;
    int errors = 0;
    int samples_checked = 0;

    // **********************************************************
    // Structure
    // **********************************************************
    // Chain a loops data straight back, chain b inverts it, so the two are told apart.
    jtag_isp_flash_programmer #(.ID_VER(ID_V), .ID_PART(ID_P), .ID_MFR(ID_M), .ERASE_CYC(40), .PROG_CYC(20)) uut (
        .CLK_I(clk_i), .RST_I(rst_i), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .TDO_O(tdo),
        .TDO_OE_O(tdo_oe), .USER_TAP_STATE_O(user_state), .USER_TCK_O(user_tck), .USER_TMS_O(user_tms),
        .USER_TDI_O(user_tdi), .USER_SEL_A_O(sel_a), .USER_SEL_B_O(sel_b), .USER_TDO_A_I(user_tdi),
        .USER_TDO_B_I(~user_tdi), .USER_PIN_OUT_I(core_out), .USER_PIN_OE_I(core_oe), .PIN_OUT_O(pin_out),
        .PIN_OE_O(pin_oe), .PIN_PULLUP_O(pin_pu), .ISP_MODE_O(isp_mode), .PULSE_BUSY_O(busy));
    jtag_prog_model prog (.clk_i(clk_i), .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

    // Clock of 8 ns period.
    always #4 clk_i = ~clk_i;

    // Sticky flags catch short-lived outputs that a task cannot sample at the right moment.
    always @(posedge clk_i) begin
        if (rst_i) begin
            oe_seen <= 1'b0;
            utck_seen <= 1'b0;
        end else begin
            if (tdo_oe) oe_seen <= 1'b1;
            if (user_tck) utck_seen <= 1'b1;
        end
    end

    // **********************************************************
    // Shared tasks
    // **********************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Only documented codes are ever loaded; the capture pattern proves the length.
    task automatic ld_ir(input logic [9:0] code);
        logic [31:0] d;
        prog.scan(1'b1, {22'h0, code}, `IR_LEN, d);
        check("ir_capture", d, 32'h1);
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] v, input int n);
        logic [31:0] d;
        ld_ir(`IR_ADDR);
        prog.scan(1'b0, {25'h0, a}, 7, d);
        ld_ir(`IR_DATA);
        prog.scan(1'b0, {16'h0, v}, 16, d);
        ld_ir(`IR_PROGRAM);
        check("prog_busy", busy, 1'b1);
        prog.idle(n);
    endtask

    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        logic [31:0] d;
        ld_ir(`IR_ADDR);
        prog.scan(1'b0, {25'h0, a}, 7, d);
        ld_ir(`IR_VERIFY);
        prog.scan(1'b0, 32'h0, 16, d);
        check("verify", d, exp);
    endtask

    // **********************************************************
    // Scenarios
    // **********************************************************
    task automatic t_idcode();
        logic [31:0] d;
        check("user_oe", pin_oe, core_oe);
        ld_ir(`IR_IDCODE);
        prog.scan(1'b0, 32'h0, 32, d);
        check("idcode", d, {ID_V, ID_P, ID_M, 1'b1});
        check("id_lsb", d[0], 1'b1);
        check("tdo_oe_shift", oe_seen, 1'b1);
        check("user_tck_off", utck_seen, 1'b0);
    endtask

    task automatic t_user();
        logic [31:0] d;
        for (int k = 0; k < 2; k++) begin
            ld_ir(k ? `IR_USER_B : `IR_USER_A);
            check("user_state", user_state, isp_pkg::RTI);
            check("sel_a", sel_a, k == 0);
            check("sel_b", sel_b, k == 1);
            check("tdo_oe_idle", tdo_oe, 1'b0);
            prog.scan(1'b0, 32'h96, 8, d);
            check("user_chain", d, k ? 32'hd3 : 32'h2c);
            check("user_tck_seen", utck_seen, 1'b1);
            check("user_tms_idle", user_tms, 1'b0);
        end
        ld_ir(`IR_IDCODE);
        check("user_state_off", user_state, 16'h0);
    endtask

    // Pin codes 0..3 repeat from pin 0, so every clamp choice is set twice.
    task automatic t_clamp();
        logic [31:0] d;
        ld_ir(`IR_ISP_ENTER);
        check("isp_mode", isp_mode, 1'b1);
        check("float_oe", pin_oe, 8'h00);
        check("pullup", pin_pu, 8'hff);
        ld_ir(`IR_CLAMP);
        prog.scan(1'b0, 32'he4e4, 16, d);
        check("clamp_oe", pin_oe, 8'h67);
        check("clamp_out", pin_out & pin_oe, 8'h22);
        ld_ir(`IR_ISP_EXIT);
        check("exit_oe", pin_oe, core_oe);
        check("exit_out", pin_out, core_out);
    endtask

    task automatic t_program();
        ld_ir(`IR_ISP_ENTER);
        ld_ir(`IR_ERASE_ALL);
        check("erase_busy", busy, 1'b1);
        prog.idle(2);
        check("erase_mid", busy, 1'b1);
        prog.idle(4);
        check("erase_done", busy, 1'b0);
        wr(7'h05, 16'h1234, 0);
        rd(7'h05, 16'hffff);
        check("abort_busy", busy, 1'b0);
        wr(7'h05, 16'h1234, 3);
        check("prog_done", busy, 1'b0);
        wr(7'h05, 16'hff0f, 3);
        wr(7'h45, 16'hbeef, 3);
        rd(7'h05, 16'h1204);
        rd(7'h45, 16'hbeef);
        ld_ir(`IR_ERASE_UFM);
        prog.idle(6);
        rd(7'h45, 16'hffff);
        rd(7'h05, 16'h1204);
        ld_ir(`IR_ISP_EXIT);
        check("undone_oe", pin_oe, 8'h00);
        ld_ir(`IR_ISP_ENTER);
        wr(7'h3f, 16'h0000, 3);
        core_out = 8'ha5;
        ld_ir(`IR_ISP_EXIT);
        check("done_oe", pin_oe, core_oe);
        check("done_out", pin_out, core_out);
        check("mode_off", isp_mode, 1'b0);
    endtask

    // **********************************************************
    // Sequence
    // **********************************************************
    // Identity is read before any erase or program, in the documented step order.
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        core_out = 8'h5a;
        core_oe = 8'h0f;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        prog.reset_tap();
        t_idcode();
        t_user();
        t_clamp();
        t_program();
        wrap_up();
    end

    // A hang is cut short and counted as a mismatch.
    initial begin
        repeat (100000) @(posedge clk_i);
        check("run_length", 32'h1, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
